// file: design/cbfm_consts.svh
`ifndef CBFM_CONSTS_SVH
`define CBFM_CONSTS_SVH

// ----------------------------------------------------------------------
// Clock and timeout figures
// ----------------------------------------------------------------------
// Clock period in picoseconds (200 MHz)
`define CBFM_CLK_PERIOD_PS 5000
// Failure timeout in nanoseconds
`define CBFM_TIMEOUT_NS 40000
// Timeout in clock cycles, rounded down
`define CBFM_TIMEOUT_CYC ((`CBFM_TIMEOUT_NS * 1000) / `CBFM_CLK_PERIOD_PS)

// ----------------------------------------------------------------------
// Thermal figures, degrees Celsius, applied by the sensing comparators
// ----------------------------------------------------------------------
`define CBFM_TEMP_SHUT_C 165
`define CBFM_TEMP_HYST_C 15

// ----------------------------------------------------------------------
// Pulse and edge counting
// ----------------------------------------------------------------------
// Pulse count difference that declares a wire failure
`define CBFM_PULSE_DIFF 3'h4
// Reference pulses needed before a recovery decision
`define CBFM_REC_PULSES 3'h4
// Edges on the failed wire by the fourth rising edge: three whole
// pulses and one more rise, since the decision is taken at that rise
`define CBFM_REC_EDGES 4'h7
// Saturation values of the counters
`define CBFM_PCNT_MAX 3'h7
`define CBFM_ECNT_MAX 4'hf

// ----------------------------------------------------------------------
// Wire and timer indices
// ----------------------------------------------------------------------
`define CBFM_W_HI 0
`define CBFM_W_LO 1
`define CBFM_T_HI_DOM 0
`define CBFM_T_LO_DOM 1
`define CBFM_T_RECES 2
`define CBFM_T_OV_SET 3
`define CBFM_T_OV_CLR 4
`define CBFM_NUM_TIMERS 5

`endif

// file: design/cbfm_pkg.sv
// ----------------------------------------------------------------------
// Types of the bus failure manager
// ----------------------------------------------------------------------
package cbfm_pkg;

  // Failure state; open high wire and high wire to ground share a state
  typedef enum logic [2:0] {
    ST_OK      = 3'b000,
    ST_HI_LOST = 3'b001,
    ST_LO_OPEN = 3'b010,
    ST_HI_BATT = 3'b011,
    ST_LO_GND  = 3'b100,
    ST_LO_BATT = 3'b101
  } cbfm_state_t;

  // Receiver sensing mode
  typedef enum logic [1:0] {
    RX_DIFF = 2'b00,
    RX_HI   = 2'b01,
    RX_LO   = 2'b10
  } cbfm_rxmode_t;

endpackage : cbfm_pkg

// file: design/cbfm_timer.sv
`timescale 1ns/1ps
`include "cbfm_consts.svh"

// ----------------------------------------------------------------------
// Failure timeout counter
// ----------------------------------------------------------------------
module cbfm_timer #(
  parameter logic [15:0] TERM = 16'h0010
) (
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic cond_in,
  input wire logic restart_in,
  output logic expired_out
);

  logic [15:0] cnt_r; // Cycles the condition has held
  logic [15:0] cnt_nxt; // Next count

  // Count while held; any break restarts the wait from zero
  // restart on interruption
  always_comb begin
    cnt_nxt = cnt_r;
    if (restart_in || !cond_in) begin
      cnt_nxt = 16'h0000;
    end else if (cnt_r != TERM) begin
      cnt_nxt = cnt_r + 16'h0001;
    end
  end

  // Register the count
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      cnt_r <= 16'h0000;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  // Expiry stays high while the condition keeps holding and no restart comes
  assign expired_out = (cnt_r == TERM);

  // Checks
  timer_restart_a: assert property (@(posedge clk_in) disable iff (srst_in)
    !cond_in |=> cnt_r == 16'h0000)
    else $error("timeout count not restarted");

endmodule : cbfm_timer

// file: design/cbfm_top.sv
// Operation
// - Overtemperature disables drivers until cooled past hysteresis
// - Detector moves switches to per-failure state
// - Fault flag low during failure, high after
// - Stuck-dominant shorts detected in any mode except while a short state is held; low battery short and pulse failures normal mode only
// - High wire lost when pulse counts differ four
// - Low wire open when pulse counts differ four
// - Open or grounded high keeps differential operation
// - Open high recovery after four pulse comparison
// - Open low recovery after four pulse comparison
// - High ground recovery by edge count comparison
// - High stuck dominant past timeout is failure
// - High battery short: high driver, termination off
// - Low stuck dominant past timeout is failure
// - Low ground short: low driver, termination off
// - Recessive for timeout returns to differential
// - Low overvoltage held for timeout is failure
// - Low battery short opens low termination only
// - Overvoltage gone for timeout recovers
`timescale 1ns/1ps
`include "cbfm_consts.svh"

module cbfm_top #(
  parameter logic [15:0] TIMEOUT_CYC = 16'(`CBFM_TIMEOUT_CYC)
) (
  input wire logic CLK_IN,
  input wire logic SRST_IN,
  input wire logic NORMAL_MODE_IN,
  input wire logic TXD_IN,
  input wire logic HI_DOM_IN,
  input wire logic LO_DOM_IN,
  input wire logic DIFF_DOM_IN,
  input wire logic LO_OVERV_IN,
  input wire logic OVERTEMP_IN,
  input wire logic TEMP_COOL_IN,
  output logic RXD_OUT,
  output logic HI_DRV_EN_OUT,
  output logic LO_DRV_EN_OUT,
  output logic HI_DRIVE_DOM_OUT,
  output logic LO_DRIVE_DOM_OUT,
  output logic HIGH_TERM_SWITCH_OUT,
  output logic LOW_TERM_SWITCH_OUT,
  output logic [1:0] RX_MODE_OUT,
  output logic [2:0] FAIL_STATE_OUT,
  output logic ERR_N_OUT
);

  // --------------------------------------------------------------------
  // Declarations
  // --------------------------------------------------------------------
  cbfm_pkg::cbfm_state_t st_r; // Failure state
  cbfm_pkg::cbfm_state_t st_nxt; // Next failure state
  logic therm_off_r; // Drivers held off by heat
  logic therm_off_nxt; // Next thermal latch
  logic [1:0] dom_q_r; // Wire levels of the previous cycle
  logic [1:0] dom_now; // Wire levels of this cycle
  logic [2:0] pcnt_r [2]; // Pulse count per wire
  logic [2:0] pcnt_nxt [2]; // Next pulse counts
  logic [3:0] ecnt_r [2]; // Edge count per wire
  logic [3:0] ecnt_nxt [2]; // Next edge counts
  logic [`CBFM_NUM_TIMERS-1:0] t_cond; // Conditions being timed
  logic [`CBFM_NUM_TIMERS-1:0] t_exp; // Conditions held a full timeout
  logic st_chg; // State changes at this edge
  logic rxd_nxt; // Next receive data
  logic hi_en_nxt; // Next high driver enable
  logic lo_en_nxt; // Next low driver enable
  logic hi_term_nxt; // Next high termination switch
  logic lo_term_nxt; // Next low termination switch
  cbfm_pkg::cbfm_rxmode_t rx_nxt; // Next receive mode

  // Saturating increment of a pulse count
  function automatic logic [2:0] pinc(input logic [2:0] c,
                                      input logic hit);
    pinc = (hit && c != `CBFM_PCNT_MAX) ? c + 3'h1 : c;
  endfunction : pinc

  // Saturating increment of an edge count
  function automatic logic [3:0] einc(input logic [3:0] c,
                                      input logic hit);
    einc = (hit && c != `CBFM_ECNT_MAX) ? c + 4'h1 : c;
  endfunction : einc

  // --------------------------------------------------------------------
  // Timeout timers
  // --------------------------------------------------------------------
  // Conditions watched for a full timeout
  always_comb begin
    t_cond[`CBFM_T_HI_DOM] = HI_DOM_IN;
    t_cond[`CBFM_T_LO_DOM] = LO_DOM_IN;
    t_cond[`CBFM_T_RECES] = !DIFF_DOM_IN;
    t_cond[`CBFM_T_OV_SET] = LO_OVERV_IN;
    t_cond[`CBFM_T_OV_CLR] = !LO_OVERV_IN;
  end

  // Every timer restarts when the state moves, so each decision
  // waits a full timeout counted inside its own state
  genvar gi;
  generate
    for (gi = 0; gi < `CBFM_NUM_TIMERS; gi++) begin : g_tmr
      cbfm_timer #(.TERM(TIMEOUT_CYC)) u_tmr (
        .clk_in(CLK_IN),
        .srst_in(SRST_IN),
        .cond_in(t_cond[gi]),
        .restart_in(st_chg),
        .expired_out(t_exp[gi])
      );
    end
  endgenerate

  // --------------------------------------------------------------------
  // Failure state machine
  // --------------------------------------------------------------------
  // Pulse failures and the low battery short are judged only in normal mode; stuck-dominant shorts in any mode
  always_comb begin
    st_nxt = st_r;
    case (st_r)
      cbfm_pkg::ST_OK: begin
        if (NORMAL_MODE_IN && t_exp[`CBFM_T_OV_SET]) begin
          st_nxt = cbfm_pkg::ST_LO_BATT;
        end else if (NORMAL_MODE_IN &&
                     pcnt_r[`CBFM_W_LO] == `CBFM_PULSE_DIFF) begin
          st_nxt = cbfm_pkg::ST_HI_LOST;
        end else if (NORMAL_MODE_IN &&
                     pcnt_r[`CBFM_W_HI] == `CBFM_PULSE_DIFF) begin
          st_nxt = cbfm_pkg::ST_LO_OPEN;
        end
      end
      cbfm_pkg::ST_HI_LOST: begin
        if (pcnt_r[`CBFM_W_LO] >= `CBFM_REC_PULSES &&
            pcnt_r[`CBFM_W_HI] >= `CBFM_REC_PULSES &&
            ecnt_r[`CBFM_W_HI] >= `CBFM_REC_EDGES) begin
          st_nxt = cbfm_pkg::ST_OK;
        end
      end
      cbfm_pkg::ST_LO_OPEN: begin
        if (pcnt_r[`CBFM_W_HI] >= `CBFM_REC_PULSES &&
            pcnt_r[`CBFM_W_LO] >= `CBFM_REC_PULSES) begin
          st_nxt = cbfm_pkg::ST_OK;
        end
      end
      cbfm_pkg::ST_HI_BATT, cbfm_pkg::ST_LO_GND: begin
        if (t_exp[`CBFM_T_RECES]) begin
          st_nxt = cbfm_pkg::ST_OK;
        end
      end
      cbfm_pkg::ST_LO_BATT: begin
        if (t_exp[`CBFM_T_OV_CLR]) begin
          st_nxt = cbfm_pkg::ST_OK;
        end
      end
      default: begin
        st_nxt = cbfm_pkg::ST_OK;
      end
    endcase
    if (st_r != cbfm_pkg::ST_HI_BATT && st_r != cbfm_pkg::ST_LO_GND) begin
      if (t_exp[`CBFM_T_HI_DOM]) begin
        st_nxt = cbfm_pkg::ST_HI_BATT;
      end else if (t_exp[`CBFM_T_LO_DOM]) begin
        st_nxt = cbfm_pkg::ST_LO_GND;
      end
    end
  end

  assign st_chg = (st_nxt != st_r);

  // Register the state
  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      st_r <= cbfm_pkg::ST_OK;
    end else begin
      st_r <= st_nxt;
    end
  end

  // --------------------------------------------------------------------
  // Pulse and edge counters
  // --------------------------------------------------------------------
  assign dom_now = {LO_DOM_IN, HI_DOM_IN};

  // Without a failure both counts are trimmed together, so what stays
  // is the difference; in a failure state they count freely
  always_comb begin
    for (int w = 0; w < 2; w++) begin
      pcnt_nxt[w] = pinc(pcnt_r[w], dom_now[w] && !dom_q_r[w]);
      ecnt_nxt[w] = einc(ecnt_r[w], dom_now[w] != dom_q_r[w]);
    end
    if (st_r == cbfm_pkg::ST_OK) begin
      ecnt_nxt[0] = 4'h0;
      ecnt_nxt[1] = 4'h0;
      if (pcnt_nxt[0] != 3'h0 && pcnt_nxt[1] != 3'h0) begin
        pcnt_nxt[0] = pcnt_nxt[0] - 3'h1;
        pcnt_nxt[1] = pcnt_nxt[1] - 3'h1;
      end
    end
    // Reference wire reached four without a match: try again
    if ((st_r == cbfm_pkg::ST_HI_LOST &&
         pcnt_r[`CBFM_W_LO] >= `CBFM_REC_PULSES) ||
        (st_r == cbfm_pkg::ST_LO_OPEN &&
         pcnt_r[`CBFM_W_HI] >= `CBFM_REC_PULSES)) begin
      for (int w = 0; w < 2; w++) begin
        pcnt_nxt[w] = 3'h0;
        ecnt_nxt[w] = 4'h0;
      end
    end
    if (st_chg || !NORMAL_MODE_IN) begin
      for (int w = 0; w < 2; w++) begin
        pcnt_nxt[w] = 3'h0;
        ecnt_nxt[w] = 4'h0;
      end
    end
  end

  // Register counters and previous wire levels
  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      dom_q_r <= 2'h0;
      for (int w = 0; w < 2; w++) begin
        pcnt_r[w] <= 3'h0;
        ecnt_r[w] <= 4'h0;
      end
    end else begin
      dom_q_r <= dom_now;
      for (int w = 0; w < 2; w++) begin
        pcnt_r[w] <= pcnt_nxt[w];
        ecnt_r[w] <= ecnt_nxt[w];
      end
    end
  end

  // --------------------------------------------------------------------
  // Thermal latch and switch outputs
  // --------------------------------------------------------------------
  // Outputs follow the next state so they line up with st_r
  always_comb begin
    // off when hot, on when cool
    therm_off_nxt = therm_off_r ? !TEMP_COOL_IN : OVERTEMP_IN;
    if (OVERTEMP_IN) begin
      therm_off_nxt = 1'b1;
    end
    hi_en_nxt = 1'b1;
    lo_en_nxt = 1'b1;
    hi_term_nxt = 1'b1;
    lo_term_nxt = 1'b1;
    rx_nxt = cbfm_pkg::RX_DIFF;
    case (st_nxt)
      cbfm_pkg::ST_HI_BATT: begin
        hi_en_nxt = 1'b0;
        hi_term_nxt = 1'b0;
        rx_nxt = cbfm_pkg::RX_LO;
      end
      cbfm_pkg::ST_LO_GND: begin
        lo_en_nxt = 1'b0;
        lo_term_nxt = 1'b0;
        rx_nxt = cbfm_pkg::RX_HI;
      end
      cbfm_pkg::ST_LO_BATT: begin
        lo_term_nxt = 1'b0;
        rx_nxt = cbfm_pkg::RX_HI;
      end
      default: begin
        rx_nxt = cbfm_pkg::RX_DIFF;
      end
    endcase
    if (therm_off_nxt) begin
      hi_en_nxt = 1'b0;
      lo_en_nxt = 1'b0;
    end
    // Receive data from the selected comparator, low when dominant
    case (rx_nxt)
      cbfm_pkg::RX_HI: rxd_nxt = !HI_DOM_IN;
      cbfm_pkg::RX_LO: rxd_nxt = !LO_DOM_IN;
      default: rxd_nxt = !DIFF_DOM_IN;
    endcase
  end

  // Register all outputs
  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      therm_off_r <= 1'b0;
      RXD_OUT <= 1'b1;
      HI_DRV_EN_OUT <= 1'b1;
      LO_DRV_EN_OUT <= 1'b1;
      HI_DRIVE_DOM_OUT <= 1'b0;
      LO_DRIVE_DOM_OUT <= 1'b0;
      HIGH_TERM_SWITCH_OUT <= 1'b1;
      LOW_TERM_SWITCH_OUT <= 1'b1;
      RX_MODE_OUT <= cbfm_pkg::RX_DIFF;
      FAIL_STATE_OUT <= cbfm_pkg::ST_OK;
      ERR_N_OUT <= 1'b1;
    end else begin
      therm_off_r <= therm_off_nxt;
      RXD_OUT <= rxd_nxt;
      HI_DRV_EN_OUT <= hi_en_nxt;
      LO_DRV_EN_OUT <= lo_en_nxt;
      HI_DRIVE_DOM_OUT <= hi_en_nxt && !TXD_IN;
      LO_DRIVE_DOM_OUT <= lo_en_nxt && !TXD_IN;
      HIGH_TERM_SWITCH_OUT <= hi_term_nxt;
      LOW_TERM_SWITCH_OUT <= lo_term_nxt;
      RX_MODE_OUT <= rx_nxt;
      FAIL_STATE_OUT <= st_nxt;
      ERR_N_OUT <= (st_nxt == cbfm_pkg::ST_OK);
    end
  end

  // --------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (SRST_IN);

  sequence s_hot;
    OVERTEMP_IN;
  endsequence

  sequence s_hi_stuck;
    st_r == cbfm_pkg::ST_OK ##0 t_exp[`CBFM_T_HI_DOM];
  endsequence

  therm_off_a: assert property (s_hot |=> !HI_DRV_EN_OUT ##0
    !LO_DRV_EN_OUT ##1 !HI_DRV_EN_OUT)
    else $error("drivers not off when hot");
  err_flag_a: assert property (
    ERR_N_OUT == (st_r == cbfm_pkg::ST_OK))
    else $error("fault flag does not follow state");
  short_any_a: assert property (s_hi_stuck |=>
    st_r == cbfm_pkg::ST_HI_BATT ##0 !ERR_N_OUT)
    else $error("high battery short missed");
  hi_lost_det_a: assert property (st_r == cbfm_pkg::ST_OK &&
    NORMAL_MODE_IN && !t_exp[`CBFM_T_HI_DOM] && !t_exp[`CBFM_T_LO_DOM] &&
    !t_exp[`CBFM_T_OV_SET] && pcnt_r[`CBFM_W_LO] == `CBFM_PULSE_DIFF
    |=> st_r == cbfm_pkg::ST_HI_LOST)
    else $error("high wire loss missed");
  lo_open_det_a: assert property (st_r == cbfm_pkg::ST_OK &&
    NORMAL_MODE_IN && !t_exp[`CBFM_T_HI_DOM] && !t_exp[`CBFM_T_LO_DOM] &&
    !t_exp[`CBFM_T_OV_SET] && pcnt_r[`CBFM_W_HI] == `CBFM_PULSE_DIFF
    |=> st_r == cbfm_pkg::ST_LO_OPEN)
    else $error("low wire open missed");
  open_diff_a: assert property (st_r inside {cbfm_pkg::ST_HI_LOST,
    cbfm_pkg::ST_LO_OPEN} |-> HIGH_TERM_SWITCH_OUT &&
    LOW_TERM_SWITCH_OUT && RX_MODE_OUT == cbfm_pkg::RX_DIFF &&
    (HI_DRV_EN_OUT || therm_off_r))
    else $error("open wire left differential mode");
  hi_batt_sw_a: assert property (st_r == cbfm_pkg::ST_HI_BATT
    |-> !HI_DRV_EN_OUT && !HIGH_TERM_SWITCH_OUT &&
    RX_MODE_OUT == cbfm_pkg::RX_LO)
    else $error("high battery switches wrong");
  lo_gnd_sw_a: assert property (st_r == cbfm_pkg::ST_LO_GND
    |-> !LO_DRV_EN_OUT && !LOW_TERM_SWITCH_OUT &&
    RX_MODE_OUT == cbfm_pkg::RX_HI)
    else $error("low ground switches wrong");
  short_rec_a: assert property (st_r == cbfm_pkg::ST_LO_GND &&
    t_exp[`CBFM_T_RECES] |=> st_r == cbfm_pkg::ST_OK ##0
    RX_MODE_OUT == cbfm_pkg::RX_DIFF)
    else $error("short recovery missed");
  lo_batt_sw_a: assert property (st_r == cbfm_pkg::ST_LO_BATT
    |-> !LOW_TERM_SWITCH_OUT && HIGH_TERM_SWITCH_OUT &&
    RX_MODE_OUT == cbfm_pkg::RX_HI)
    else $error("low battery switches wrong");
  cnt_clear_a: assert property (st_r != $past(st_r) |->
    pcnt_r[0] == 3'h0 && pcnt_r[1] == 3'h0)
    else $error("pulse counts not cleared");

endmodule : cbfm_top

// file: testbench/cbfm_bus_model.sv
`timescale 1ns/1ps

// ------------------------------------------------------------------
// Bus wires and line comparators seen by the failure manager
// ------------------------------------------------------------------
module cbfm_bus_model (
  input wire logic [2:0] fault_in,
  input wire logic node_dom_in,
  input wire logic hi_drive_dom_in,
  input wire logic lo_drive_dom_in,
  output logic hi_dom_out,
  output logic lo_dom_out,
  output logic diff_dom_out,
  output logic lo_overv_out
);
  // Wired dominant level of this node and of the other nodes
  logic bus_dom;

  // Fault codes: 1 high open, 2 low open, 3 high to battery,
  // 4 low to ground, 5 high to ground, 6 low to battery
  always_comb begin
    bus_dom = node_dom_in | hi_drive_dom_in | lo_drive_dom_in;
    hi_dom_out = bus_dom;
    lo_dom_out = bus_dom;
    diff_dom_out = bus_dom;
    lo_overv_out = 1'b0;
    case (fault_in)
      // A dead high wire never crosses its threshold
      3'h1, 3'h5: begin
        hi_dom_out = 1'b0;
      end
      3'h2: begin
        lo_dom_out = 1'b0;
      end
      // Stuck shorts also pin the differential comparator
      3'h3: begin
        hi_dom_out = 1'b1;
        diff_dom_out = 1'b1;
      end
      3'h4: begin
        lo_dom_out = 1'b1;
        diff_dom_out = 1'b1;
      end
      3'h6: begin
        lo_overv_out = 1'b1;
      end
      default: begin
      end
    endcase
  end
endmodule : cbfm_bus_model

// file: testbench/testbench.sv
`timescale 1ns/1ps

module testbench;
  // ------------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------------
  // Short timeout so every timed wait stays small
  localparam int TMO = 16;
  logic clk_in = 1'b0;
  logic srst = 1'b1;
  logic normal = 1'b1;
  logic txd = 1'b1;
  logic ovt = 1'b0;
  // Junction starts cold, below the release point
  logic cool = 1'b1;
  logic [2:0] fault = 3'h0;
  logic node = 1'b0;
  logic hi_dom, lo_dom, diff_dom, overv;
  logic rxd, hi_en, lo_en, hi_dd, lo_dd, hterm, lterm, err_n;
  logic [1:0] rxm;
  logic [2:0] st;
  int failures = 0;
  int n_tests = 0;
  int cyc = 0;

  // ------------------------------------------------------------------
  // Clock, design and bus
  // ------------------------------------------------------------------
  always #2.5 clk_in = ~clk_in;

  cbfm_top #(.TIMEOUT_CYC(16'(TMO))) u_dut (
    .CLK_IN(clk_in), .SRST_IN(srst), .NORMAL_MODE_IN(normal),
    .TXD_IN(txd), .HI_DOM_IN(hi_dom), .LO_DOM_IN(lo_dom),
    .DIFF_DOM_IN(diff_dom), .LO_OVERV_IN(overv), .OVERTEMP_IN(ovt),
    .TEMP_COOL_IN(cool), .RXD_OUT(rxd), .HI_DRV_EN_OUT(hi_en),
    .LO_DRV_EN_OUT(lo_en), .HI_DRIVE_DOM_OUT(hi_dd),
    .LO_DRIVE_DOM_OUT(lo_dd), .HIGH_TERM_SWITCH_OUT(hterm),
    .LOW_TERM_SWITCH_OUT(lterm), .RX_MODE_OUT(rxm),
    .FAIL_STATE_OUT(st), .ERR_N_OUT(err_n));

  cbfm_bus_model u_bus (
    .fault_in(fault), .node_dom_in(node), .hi_drive_dom_in(hi_dd),
    .lo_drive_dom_in(lo_dd), .hi_dom_out(hi_dom), .lo_dom_out(lo_dom),
    .diff_dom_out(diff_dom), .lo_overv_out(overv));

  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : tally_and_finish

  // Hang guard: whole run needs well under a thousand cycles
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      failures = failures + 1;
      $display("[FAIL] run expected end seen hang");
      tally_and_finish();
    end
  end

  task automatic chk(input string nm, input logic [2:0] seen,
                     input logic [2:0] exp);
    n_tests = n_tests + 1;
    if (seen !== exp) begin
      failures = failures + 1;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // Let n edges pass, then look once everything has settled
  task automatic step(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask : step

  // Bounded wait for a failure state
  task automatic wait_st(input logic [2:0] s, input int lim);
    for (int k = 0; k < lim && st !== s; k++) begin
      step(1);
    end
    chk("state", st, s);
  endtask : wait_st

  // Full switch picture of one state
  task automatic sw(input logic [2:0] s, input logic e,
                    input logic [1:0] m, input logic he, input logic le,
                    input logic ht, input logic lt);
    chk("state", st, s);
    chk("err_n", err_n, e);
    chk("rx_mode", rxm, m);
    chk("hi_drv_en", hi_en, he);
    chk("lo_drv_en", lo_en, le);
    chk("high_term", hterm, ht);
    chk("low_term", lterm, lt);
  endtask : sw

  task automatic set_fault(input logic [2:0] f);
    @(posedge clk_in);
    fault <= f;
  endtask : set_fault

  // Other nodes send n short dominant pulses
  task automatic pulses(input int n);
    repeat (n) begin
      @(posedge clk_in);
      node <= 1'b1;
      repeat (2) @(posedge clk_in);
      node <= 1'b0;
      repeat (2) @(posedge clk_in);
    end
    #1;
  endtask : pulses

  // Own transmitter drives dominant and the receiver sees it
  task automatic tx_check(input logic h, input logic l);
    @(posedge clk_in);
    txd <= 1'b0;
    step(2);
    chk("hi_drive_dom", hi_dd, h);
    chk("lo_drive_dom", lo_dd, l);
    chk("rxd", rxd, 1'b0);
    @(posedge clk_in);
    txd <= 1'b1;
    // One edge for the drive to fall, one more for the receiver, one to spare
    step(3);
    chk("rxd", rxd, 1'b1);
  endtask : tx_check

  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  // idle switch state
  task automatic t_idle();
    sw(3'h0, 1'b1, 2'h0, 1'b1, 1'b1, 1'b1, 1'b1);
    tx_check(1'b1, 1'b1);
    chk("rxd", rxd, 1'b1);
    $display("test idle done");
  endtask : t_idle

  // high battery short, with a restarted timer
  task automatic t_hi_batt();
    set_fault(3'h3);
    step(12);
    set_fault(3'h0);
    set_fault(3'h3);
    step(TMO - 2);
    chk("state", st, 3'h0);
    wait_st(3'h3, 8);
    sw(3'h3, 1'b0, 2'h2, 1'b0, 1'b1, 1'b0, 1'b1);
    tx_check(1'b0, 1'b1);
    set_fault(3'h0);
    step(TMO - 2);
    chk("state", st, 3'h3);
    wait_st(3'h0, 8);
    sw(3'h0, 1'b1, 2'h0, 1'b1, 1'b1, 1'b1, 1'b1);
    $display("test high battery done");
  endtask : t_hi_batt

  // low ground short in low-power mode
  task automatic t_lo_gnd();
    @(posedge clk_in);
    normal <= 1'b0;
    set_fault(3'h1);
    pulses(5);
    chk("state", st, 3'h0);
    set_fault(3'h4);
    wait_st(3'h4, TMO + 8);
    sw(3'h4, 1'b0, 2'h1, 1'b1, 1'b0, 1'b1, 1'b0);
    @(posedge clk_in);
    normal <= 1'b1;
    tx_check(1'b1, 1'b0);
    set_fault(3'h0);
    wait_st(3'h0, TMO + 8);
    $display("test low ground done");
  endtask : t_lo_gnd

  // lost high wire, counted and recovered
  task automatic t_hi_open(input logic [2:0] f);
    set_fault(f);
    pulses(3);
    chk("state", st, 3'h0);
    pulses(1);
    wait_st(3'h1, 6);
    sw(3'h1, 1'b0, 2'h0, 1'b1, 1'b1, 1'b1, 1'b1);
    set_fault(3'h0);
    pulses(5);
    wait_st(3'h0, 6);
    chk("err_n", err_n, 1'b1);
    $display("test high wire lost done");
  endtask : t_hi_open

  // open low wire, counted and recovered
  task automatic t_lo_open();
    set_fault(3'h2);
    pulses(3);
    chk("state", st, 3'h0);
    pulses(1);
    wait_st(3'h2, 6);
    sw(3'h2, 1'b0, 2'h0, 1'b1, 1'b1, 1'b1, 1'b1);
    set_fault(3'h0);
    pulses(5);
    wait_st(3'h0, 6);
    $display("test low open done");
  endtask : t_lo_open

  task automatic t_lo_batt();
    set_fault(3'h6);
    step(TMO - 2);
    chk("state", st, 3'h0);
    wait_st(3'h5, 8);
    sw(3'h5, 1'b0, 2'h1, 1'b1, 1'b1, 1'b1, 1'b0);
    set_fault(3'h0);
    step(TMO - 2);
    chk("state", st, 3'h5);
    wait_st(3'h0, 8);
    $display("test low battery done");
  endtask : t_lo_batt

  task automatic t_thermal();
    @(posedge clk_in);
    ovt <= 1'b1;
    cool <= 1'b0;
    step(2);
    chk("hi_drv_en", hi_en, 1'b0);
    chk("lo_drv_en", lo_en, 1'b0);
    @(posedge clk_in);
    ovt <= 1'b0;
    step(4);
    chk("hi_drv_en", hi_en, 1'b0);
    @(posedge clk_in);
    cool <= 1'b1;
    step(2);
    chk("hi_drv_en", hi_en, 1'b1);
    chk("lo_drv_en", lo_en, 1'b1);
    $display("test thermal done");
  endtask : t_thermal

  // ------------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------------
  initial begin
    repeat (16) @(posedge clk_in);
    srst <= 1'b0;
    step(2);
    t_idle();
    t_hi_batt();
    t_lo_gnd();
    t_hi_open(3'h1);
    t_hi_open(3'h5);
    t_lo_open();
    t_lo_batt();
    t_thermal();
    tally_and_finish();
  end
endmodule : testbench
